// ---- inc/pcm_codec_pkg.sv ----
// shared constants and carrier types for the companding pcm word codec
package pcm_codec_pkg;

  // word and sample widths
  localparam int LIN_W     = 14;
  localparam int SLOT_W    = 5;
  localparam int WORD_W    = 8;
  localparam int MAX_SLOTS = 32;
  localparam int N_CHORDS  = 8;

  // clipping magnitudes and chord geometry
  localparam logic [LIN_W-1:0] MU_CLIP       = 14'h1FDF;
  localparam logic [LIN_W-1:0] A_CLIP        = 14'h0FFF;
  localparam logic [LIN_W-1:0] CHORD_BIAS    = 14'h0021;
  localparam logic [LIN_W-1:0] A_CHORD1_LOW  = 14'h0020;
  localparam logic [LIN_W-1:0] A_CHORD2_LOW  = 14'h0040;
  localparam int               MU_CHORD_BASE = 5;
  localparam int               A_CHORD_BASE  = 4;

  // transmit inversion masks
  localparam logic [WORD_W-1:0] MU_MASK = 8'h7F;
  localparam logic [WORD_W-1:0] A_MASK  = 8'h55;

  // reference codes at the ends and centre of each law
  localparam logic [WORD_W-1:0] MU_POS_FULL = 8'h80;
  localparam logic [WORD_W-1:0] MU_POS_CTR  = 8'hFF;
  localparam logic [WORD_W-1:0] MU_NEG_CTR  = 8'h7F;
  localparam logic [WORD_W-1:0] MU_NEG_FULL = 8'h00;
  localparam logic [WORD_W-1:0] A_POS_FULL  = 8'hAA;
  localparam logic [WORD_W-1:0] A_POS_CTR   = 8'hD5;
  localparam logic [WORD_W-1:0] A_NEG_CTR   = 8'h55;
  localparam logic [WORD_W-1:0] A_NEG_FULL  = 8'h2A;

  // frame timing
  localparam int CLK_MHZ  = 20;
  localparam int FRAME_US = 125;
  localparam int BIT_NS   = 500;
  localparam int FRAME_CYC      = FRAME_US * CLK_MHZ;
  localparam int BIT_CYC        = BIT_NS * CLK_MHZ / 1000;
  localparam int BIT_MID        = BIT_CYC / 2;
  localparam int BITS_PER_FRAME = FRAME_CYC / BIT_CYC;
  localparam logic [SLOT_W-1:0] MU_SLOTS = 5'h18;
  localparam logic [SLOT_W-1:0] A_SLOTS  = 5'h1E;

  typedef struct packed {
    logic       sign;
    logic [2:0] chord;
    logic [3:0] step;
  } pcm_word_t;

  typedef struct packed {
    logic [SLOT_W-1:0]       slot;
    logic signed [LIN_W-1:0] value;
  } lin_sample_t;

endpackage

// ---- hdl/compand_encoder.sv ----
// linear sample to companded 8-bit word, combinational
`timescale 1ns/1ns
module compand_encoder
  import pcm_codec_pkg::*;
(
  // law choice
  input  wire logic                    law_a,
  // linear sample
  input  wire logic signed [LIN_W-1:0] value,
  // companded word before and after line inversion
  output pcm_word_t                    natural,
  output logic [WORD_W-1:0]            code
);

  logic [LIN_W-1:0] abs_v;
  logic [LIN_W-1:0] work;
  logic [2:0]       chord;
  logic [LIN_W-1:0] shifted;
  int               base;

  // clamp, bias and find the chord from the leading one
  always_comb begin
    // ones' complement magnitude: -1 lands in the innermost negative step,
    // which gives the second zero code and keeps both halves symmetric
    abs_v   = value[LIN_W-1] ? (~value) : value;
    base    = law_a ? A_CHORD_BASE : MU_CHORD_BASE;
    if (law_a) begin
      work = (abs_v > A_CLIP) ? A_CLIP : abs_v;
    end else begin
      work = ((abs_v > MU_CLIP) ? MU_CLIP : abs_v) + CHORD_BIAS;
      // the biased clip sits one past the top chord, so pin it to the top code
      if (work[LIN_W-1]) begin
        work = {1'b0, {(LIN_W-1){1'b1}}};
      end
    end
    chord = 3'h0;
    // eight chords per quadrant; a-law chords 0 and 1 share step width
    for (int s = 1; s < N_CHORDS; s++) begin
      if (work[base + s]) begin
        chord = 3'(s);
      end
    end
    if (law_a) begin
      shifted = work >> ((chord == 3'h0) ? 3'h1 : chord);
    end else begin
      shifted = work >> (4'(chord) + 4'h1);
    end
    natural.sign  = ~value[LIN_W-1];
    natural.chord = chord;
    natural.step  = shifted[3:0];
  end

  // line form: a-law inverts alternate bits, mu-law the magnitude
  assign code = natural ^ (law_a ? A_MASK : MU_MASK);

endmodule

// ---- hdl/compand_decoder.sv ----
// companded 8-bit word to interval midpoint, combinational
`timescale 1ns/1ns
module compand_decoder
  import pcm_codec_pkg::*;
(
  // law choice
  input  wire logic                    law_a,
  // received line word
  input  wire logic [WORD_W-1:0]       code,
  // natural word and reconstructed amplitude
  output pcm_word_t                    natural,
  output logic signed [LIN_W-1:0]      value
);

  logic [LIN_W-1:0] base_v;
  logic [LIN_W-1:0] mag;

  // rebuild the centre of the interval from chord and step
  always_comb begin
    natural = code ^ (law_a ? A_MASK : MU_MASK);
    base_v  = (LIN_W'(natural.step) << 1) + CHORD_BIAS;
    if (law_a) begin
      if (natural.chord == 3'h0) begin
        mag = (LIN_W'(natural.step) << 1) | 14'h0001;
      end else begin
        mag = base_v << (natural.chord - 3'h1);
      end
    end else begin
      mag = (base_v << natural.chord) - CHORD_BIAS;
    end
    value = natural.sign ? $signed(mag) : -$signed(mag);
  end

endmodule

// ---- hdl/companding_pcm_codec.sv ----
// companding pcm codec: sample intake, frame timing, tdm transmit and receive
`timescale 1ns/1ns
module companding_pcm_codec
  import pcm_codec_pkg::*;
(
  // clock and reset
  input  wire logic                  CLK,
  input  wire logic                  RST_B,
  // law select, high for a-law
  input  wire logic                  LAW_SEL,
  // linear sample intake
  input  wire logic                  SMP_VALID,
  output logic                       SMP_READY,
  input  pcm_codec_pkg::lin_sample_t SMP_IN,
  // tdm bus
  output logic                       FRAME_SYNC,
  output logic                       BIT_START,
  output logic                       TX_DATA,
  output logic                       TX_EN,
  input  wire logic                  RX_DATA,
  // decoded samples
  output logic                       DEC_VALID,
  output pcm_codec_pkg::lin_sample_t DEC_OUT
);

  logic [11:0]             frame_cnt_q;
  logic [3:0]              bit_div_q;
  logic [7:0]              bit_cnt_q;
  logic [7:0]              bit_cnt_d;
  logic                    frame_end;
  logic                    bit_tick;
  logic                    bit_mid;
  logic [SLOT_W-1:0]       n_slots;
  logic [SLOT_W-1:0]       cur_slot;
  logic [2:0]              cur_bit;
  logic [SLOT_W-1:0]       nxt_slot;
  logic [2:0]              nxt_bit;
  logic                    cur_active;
  logic                    nxt_active;
  logic                    take;
  logic [MAX_SLOTS-1:0]    taken_q;
  logic [WORD_W-1:0]       pending_q [MAX_SLOTS];
  logic [WORD_W-1:0]       tx_word_q [MAX_SLOTS];
  logic [WORD_W-1:0]       nxt_word;
  logic [WORD_W-1:0]       idle_code;
  pcm_word_t               enc_nat;
  logic [WORD_W-1:0]       enc_code;
  logic [WORD_W-2:0]       rx_shift_q;
  logic [WORD_W-1:0]       rx_word;
  pcm_word_t               dec_nat;
  logic signed [LIN_W-1:0] dec_value;
  logic                    frame_sync_q;
  logic                    bit_start_q;
  logic                    tx_data_q;
  logic                    tx_en_q;
  logic                    dec_valid_q;
  lin_sample_t             dec_out_q;
  logic [11:0]             gap_q;
  logic                    seen_sync_q;
  logic [7:0]              tx_bits_q;

  // law-dependent frame shape; slot count bounds every path
  assign n_slots   = LAW_SEL ? A_SLOTS : MU_SLOTS;
  assign idle_code = LAW_SEL ? A_POS_CTR : MU_POS_CTR;

  // timing decode
  assign frame_end  = (frame_cnt_q == 12'(FRAME_CYC - 1));
  assign bit_tick   = (bit_div_q == 4'(BIT_CYC - 1));
  assign bit_mid    = (bit_div_q == 4'(BIT_MID));
  assign bit_cnt_d  = (bit_cnt_q == 8'(BITS_PER_FRAME - 1)) ? 8'h00 : bit_cnt_q + 8'h01;
  assign cur_slot   = bit_cnt_q[7:3];
  assign cur_bit    = bit_cnt_q[2:0];
  assign nxt_slot   = bit_cnt_d[7:3];
  assign nxt_bit    = bit_cnt_d[2:0];
  assign cur_active = (cur_slot < n_slots);
  assign nxt_active = (nxt_slot < n_slots);

  // frame counter; reset lands on the last cycle so a frame starts at once
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      frame_cnt_q <= 12'(FRAME_CYC - 1);
    end else if (frame_end) begin
      frame_cnt_q <= 12'h000;
    end else begin
      frame_cnt_q <= frame_cnt_q + 12'h001;
    end
  end

  // bit divider; frame length is a whole number of bits so both wrap together
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      bit_div_q <= 4'(BIT_CYC - 1);
      bit_cnt_q <= 8'(BITS_PER_FRAME - 1);
    end else if (bit_tick) begin
      bit_div_q <= 4'h0;
      bit_cnt_q <= bit_cnt_d;
    end else begin
      bit_div_q <= bit_div_q + 4'h1;
    end
  end

  // sample intake: one per slot per frame, slots past the frame refused
  assign SMP_READY = (SMP_IN.slot < n_slots) && !taken_q[SMP_IN.slot];
  assign take      = SMP_VALID && SMP_READY;

  compand_encoder u_enc (
    .law_a   (LAW_SEL),
    .value   (SMP_IN.value),
    .natural (enc_nat),
    .code    (enc_code)
  );

  // taken flags clear at frame end, but a take in that cycle still sets
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      taken_q <= '0;
    end else begin
      for (int i = 0; i < MAX_SLOTS; i++) begin
        if (take && (SMP_IN.slot == SLOT_W'(i))) begin
          taken_q[i] <= 1'b1;
        end else if (frame_end) begin
          taken_q[i] <= 1'b0;
        end
      end
    end
  end

  // pending words fall back to the law's centre code at frame end; reset loads the mu-law centre code for both laws
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      for (int i = 0; i < MAX_SLOTS; i++) begin
        pending_q[i] <= MU_POS_CTR;
      end
    end else begin
      for (int i = 0; i < MAX_SLOTS; i++) begin
        if (take && (SMP_IN.slot == SLOT_W'(i))) begin
          pending_q[i] <= enc_code;
        end else if (frame_end) begin
          pending_q[i] <= idle_code;
        end
      end
    end
  end

  // frame-wide snapshot keeps a word steady while it is shifted out
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      for (int i = 0; i < MAX_SLOTS; i++) begin
        tx_word_q[i] <= MU_POS_CTR;
      end
    end else if (frame_end) begin
      for (int i = 0; i < MAX_SLOTS; i++) begin
        tx_word_q[i] <= pending_q[i];
      end
    end
  end

  // the first bit of a frame is read from pending, since the snapshot
  // is loaded on the same edge
  assign nxt_word = frame_end ? pending_q[nxt_slot] : tx_word_q[nxt_slot];

  // serial transmit, msb first, one word per active slot
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      tx_data_q <= 1'b0;
      tx_en_q   <= 1'b0;
    end else if (bit_tick) begin
      tx_data_q <= nxt_active ? nxt_word[3'(WORD_W - 1) - nxt_bit] : 1'b0;
      tx_en_q   <= nxt_active;
    end
  end

  // bus strobes, registered so they line up with the data
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      frame_sync_q <= 1'b0;
      bit_start_q  <= 1'b0;
    end else begin
      frame_sync_q <= frame_end;
      bit_start_q  <= bit_tick;
    end
  end

  // receive shift, sampled mid-bit for margin against skew
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      rx_shift_q <= '0;
    end else if (bit_mid && cur_active) begin
      rx_shift_q <= {rx_shift_q[WORD_W-3:0], RX_DATA};
    end
  end

  assign rx_word = {rx_shift_q, RX_DATA};

  compand_decoder u_dec (
    .law_a   (LAW_SEL),
    .code    (rx_word),
    .natural (dec_nat),
    .value   (dec_value)
  );

  // decoded sample leaves one cycle after the last bit is sampled
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      dec_valid_q <= 1'b0;
      dec_out_q   <= '0;
    end else if (bit_mid && cur_active && (cur_bit == 3'(WORD_W - 1))) begin
      dec_valid_q <= 1'b1;
      dec_out_q   <= '{slot: cur_slot, value: dec_value};
    end else begin
      dec_valid_q <= 1'b0;
    end
  end

  assign FRAME_SYNC = frame_sync_q;
  assign BIT_START  = bit_start_q;
  assign TX_DATA    = tx_data_q;
  assign TX_EN      = tx_en_q;
  assign DEC_VALID  = dec_valid_q;
  assign DEC_OUT    = dec_out_q;

  // helper counters watched only by the checks below
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      gap_q       <= 12'h000;
      seen_sync_q <= 1'b0;
      tx_bits_q   <= 8'h00;
    end else begin
      gap_q       <= frame_sync_q ? 12'h000 : gap_q + 12'h001;
      seen_sync_q <= seen_sync_q | frame_sync_q;
      tx_bits_q   <= (frame_sync_q ? 8'h00 : tx_bits_q) + 8'(bit_start_q && tx_en_q);
    end
  end

  a_sign_polarity: assert property (@(posedge CLK) disable iff (!RST_B)
    take |-> (enc_nat.sign == (SMP_IN.value >= 0)))
    else $error("polarity bit does not follow sample sign");

  a_inner_chords: assert property (@(posedge CLK) disable iff (!RST_B)
    take && LAW_SEL && (SMP_IN.value >= 0) && (SMP_IN.value < $signed(A_CHORD2_LOW)) |->
      (enc_nat.chord == ((SMP_IN.value < $signed(A_CHORD1_LOW)) ? 3'h0 : 3'h1)) &&
      (enc_nat.step == SMP_IN.value[4:1]))
    else $error("inner a-law segments coded wrongly");

  a_mu_ends: assert property (@(posedge CLK) disable iff (!RST_B)
    take && !LAW_SEL && ((SMP_IN.value >= $signed(MU_CLIP)) || (SMP_IN.value <= -$signed(MU_CLIP)))
      |-> (enc_code == ((SMP_IN.value > 0) ? MU_POS_FULL : MU_NEG_FULL)))
    else $error("mu-law full scale code wrong");

  a_mu_zero_codes: assert property (@(posedge CLK) disable iff (!RST_B)
    take && !LAW_SEL && ((SMP_IN.value == 0) || (SMP_IN.value == -1)) |->
      (enc_code == ((SMP_IN.value == 0) ? MU_POS_CTR : MU_NEG_CTR)))
    else $error("mu-law zero codes wrong");

  a_a_law_codes: assert property (@(posedge CLK) disable iff (!RST_B)
    take && LAW_SEL |->
      ((SMP_IN.value >= $signed(A_CLIP)) ? (enc_code == A_POS_FULL) :
       (SMP_IN.value <= -$signed(A_CLIP)) ? (enc_code == A_NEG_FULL) :
       (SMP_IN.value == 0) ? (enc_code == A_POS_CTR) :
       (SMP_IN.value == -1) ? (enc_code == A_NEG_CTR) : 1'b1))
    else $error("a-law reference code wrong");

  a_once_frame: assert property (@(posedge CLK) disable iff (!RST_B)
    take |=> taken_q[$past(SMP_IN.slot)] && (pending_q[$past(SMP_IN.slot)] == $past(enc_code)))
    else $error("sample not held as the channel's word for the frame");

  a_frame_period: assert property (@(posedge CLK) disable iff (!RST_B)
    FRAME_SYNC && seen_sync_q |-> (gap_q == 12'(FRAME_CYC - 1)))
    else $error("frame period is not 125 us");

  a_slot_total: assert property (@(posedge CLK) disable iff (!RST_B)
    $fell(TX_EN) |-> (tx_bits_q == {n_slots, 3'b000}))
    else $error("word count per frame wrong for the law");

  a_a_invert: assert property (@(posedge CLK) disable iff (!RST_B)
    take && LAW_SEL |-> ((enc_code ^ enc_nat) == A_MASK))
    else $error("a-law alternate bits not inverted");

  a_decode_mid: assert property (@(posedge CLK) disable iff (!RST_B)
    bit_mid && cur_active && (cur_bit == 3'(WORD_W - 1)) && LAW_SEL && (dec_nat.chord == 3'h0)
      |=> DEC_VALID && DEC_OUT.value[0])
    else $error("a-law inner step not decoded to its midpoint");

endmodule

// ---- sim/pcm_tdm_partner.sv ----
// far side of the tdm bus: collects sent words and plays receive words per slot
`timescale 1ns/1ns
module pcm_tdm_partner
  import pcm_codec_pkg::*;
(
  // clock and law
  input  wire logic CLK,
  input  wire logic law_a,
  // bus timing and transmit data from the codec
  input  wire logic FRAME_SYNC,
  input  wire logic BIT_START,
  input  wire logic TX_DATA,
  input  wire logic TX_EN,
  // receive line toward the codec
  output logic      RX_DATA
);
  logic [WORD_W-1:0] tx_word [MAX_SLOTS];
  logic [WORD_W-1:0] rx_word [MAX_SLOTS];
  logic [7:0]        cell_q    = 8'h00;
  logic [3:0]        cyc_q     = 4'h0;
  logic [6:0]        shift_q   = 7'h00;
  logic [5:0]        nslots;
  int                en_cnt    = 0;
  int                en_last   = 0;
  int                frame_len = 0;
  int                len_cnt   = 0;
  int                ncell;

  // channel count follows the law
  assign nslots = law_a ? 6'h1E : 6'h18;

  // frame length and active cell count per frame
  always @(posedge CLK) begin
    len_cnt <= (FRAME_SYNC === 1'b1) ? 1 : len_cnt + 1;
    if (FRAME_SYNC === 1'b1) begin
      frame_len <= len_cnt;
      en_last   <= en_cnt;
      en_cnt    <= 0;
    end else if (cyc_q == 4'h5 && TX_EN === 1'b1) begin
      en_cnt <= en_cnt + 1;
    end
  end

  // receive bits change just after a cell opens, far from the mid-cell sample
  always @(posedge CLK) begin
    if (BIT_START === 1'b1) begin
      ncell = (FRAME_SYNC === 1'b1) ? 0 : cell_q + 1;
      cell_q <= ncell[7:0];
      cyc_q  <= 4'h1;
      if (ncell < nslots * 8) begin
        RX_DATA <= rx_word[ncell / 8][7 - ncell % 8];
      end else begin
        RX_DATA <= ~RX_DATA;
      end
    end else begin
      cyc_q <= cyc_q + 4'h1;
      // unused cells carry no data, so the line keeps moving
      if (cell_q >= nslots * 8) begin
        RX_DATA <= ~RX_DATA;
      end
    end
  end

  // transmit bits taken mid-cell, msb first, one word per slot
  always @(posedge CLK) begin
    if (cyc_q == 4'h5) begin
      shift_q <= {shift_q[5:0], TX_DATA};
      if (cell_q % 8 == 7 && cell_q < nslots * 8) begin
        tx_word[cell_q / 8] <= {shift_q, TX_DATA};
      end
    end
  end
endmodule

// ---- sim/companding_pcm_codec_tb.sv ----
// self-checking bench for the companding pcm codec, both laws in turn
`timescale 1ns/1ns
module companding_pcm_codec_tb;
  import pcm_codec_pkg::*;
  logic                    CLK       = 1'b0;
  logic                    RST_B     = 1'b0;
  logic                    LAW_SEL   = 1'b0;
  logic                    SMP_VALID = 1'b0;
  lin_sample_t             SMP_IN    = '0;
  logic                    SMP_READY, FRAME_SYNC, BIT_START, TX_DATA, TX_EN, RX_DATA;
  logic                    DEC_VALID;
  lin_sample_t             DEC_OUT;
  logic signed [LIN_W-1:0] dec_val [MAX_SLOTS];
  int                      error_cnt   = 0;
  int                      check_count = 0;
  int                      cycles      = 0;
  localparam int LIMIT = 32'h0000_4E20;
  // per law: samples at full scale, centre, beyond clip and inside chords
  localparam logic [LIN_W-1:0] ENC_IN [2][8] = '{
    '{14'h1FDF, 14'h0000, 14'h3FFF, 14'h2021, 14'h1FFF, 14'h2000, 14'h0064, 14'h3F9C},
    '{14'h0FFF, 14'h0000, 14'h3FFF, 14'h3000, 14'h1FFF, 14'h0064, 14'h001F, 14'h0020}};
  localparam logic [WORD_W-1:0] ENC_EXP [2][8] = '{
    '{8'h80, 8'hFF, 8'h7F, 8'h00, 8'h80, 8'h00, 8'hDF, 8'h5F},
    '{8'hAA, 8'hD5, 8'h55, 8'h2A, 8'hAA, 8'hFC, 8'hDA, 8'hC5}};
  localparam logic [WORD_W-1:0] DEC_RX [2][4] = '{
    '{8'hDF, 8'h5F, 8'hFF, 8'h80}, '{8'hFC, 8'hD5, 8'hAA, 8'h55}};
  localparam logic signed [LIN_W-1:0] DEC_EXP [2][4] = '{
    '{14'h0063, 14'h3F9D, 14'h0000, 14'h1F5F}, '{14'h0066, 14'h0001, 14'h0FC0, 14'h3FFF}};

  // 20 mhz clock
  always #25 CLK = ~CLK;

  companding_pcm_codec DUT (
    .CLK(CLK), .RST_B(RST_B), .LAW_SEL(LAW_SEL), .SMP_VALID(SMP_VALID),
    .SMP_READY(SMP_READY), .SMP_IN(SMP_IN), .FRAME_SYNC(FRAME_SYNC),
    .BIT_START(BIT_START), .TX_DATA(TX_DATA), .TX_EN(TX_EN), .RX_DATA(RX_DATA),
    .DEC_VALID(DEC_VALID), .DEC_OUT(DEC_OUT));

  pcm_tdm_partner far_end (
    .CLK(CLK), .law_a(LAW_SEL), .FRAME_SYNC(FRAME_SYNC), .BIT_START(BIT_START),
    .TX_DATA(TX_DATA), .TX_EN(TX_EN), .RX_DATA(RX_DATA));

  // decoded samples land by slot; a pulse lasts one cycle so it is caught on the edge
  always @(posedge CLK) begin
    if (DEC_VALID === 1'b1) begin
      dec_val[DEC_OUT.slot] <= DEC_OUT.value;
    end
  end

  // hang guard
  always @(posedge CLK) begin
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      error_cnt++;
      stop_test();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wait_sync();
    int n;
    n = 0;
    do begin
      @(posedge CLK);
      n++;
    end while (FRAME_SYNC !== 1'b1 && n < 3000);
    if (n >= 3000) begin
      error_cnt++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, 1'b0, 1'b1);
    end
  endtask

  // one offer, readiness judged mid-cycle, request dropped after the taking edge
  task automatic offer(input logic [SLOT_W-1:0] s, input logic [LIN_W-1:0] v, input logic rdy);
    @(posedge CLK);
    SMP_VALID <= 1'b1;
    SMP_IN    <= '{slot: s, value: v};
    @(negedge CLK);
    chk(SMP_READY, rdy);
    @(posedge CLK);
    SMP_VALID <= 1'b0;
  endtask

  task automatic do_reset(input logic law);
    @(posedge CLK);
    RST_B   <= 1'b0;
    LAW_SEL <= law;
    repeat (5) @(posedge CLK);
    RST_B <= 1'b1;
  endtask

  // encode, decode and frame checks for one law, entered through a fresh reset
  task automatic run_law(input int l);
    int ns;
    ns = l ? 30 : 24;
    for (int i = 0; i < 4; i++) far_end.rx_word[i] <= DEC_RX[l][i];
    do_reset(l[0]);
    wait_sync();
    for (int i = 0; i < 8; i++) offer(SLOT_W'(i), ENC_IN[l][i], 1'b1);
    offer(SLOT_W'(0), 14'h0000, 1'b0);
    offer(SLOT_W'(ns - 1), 14'h0000, 1'b1);
    offer(SLOT_W'(ns), 14'h0000, 1'b0);
    wait_sync();
    wait_sync();
    for (int i = 0; i < 8; i++) begin
      chk(far_end.tx_word[i], ENC_EXP[l][i]);
    end
    chk(far_end.tx_word[10], l ? 8'hD5 : 8'hFF);
    chk(far_end.tx_word[ns - 1], l ? 8'hD5 : 8'hFF);
    chk(far_end.en_last, l ? 240 : 192);
    chk(far_end.frame_len, 2500);
    for (int i = 0; i < 4; i++) begin
      chk(dec_val[i], DEC_EXP[l][i]);
    end
    $display("law %0d test done, mismatches so far %0d", l, error_cnt);
  endtask

  task automatic stop_test();
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // mu-law first, then a mid-run reset into a-law
  initial begin
    run_law(0);
    run_law(1);
    stop_test();
  end
endmodule
